// >>> common/t1sc_pkg.sv
// Types shared by the signaling change bank
package t1sc_pkg;
  typedef logic [7:0]  t1sc_byte_type;
  typedef logic [23:0] t1sc_slots_type;
  typedef logic [3:0]  t1sc_int_type;
endpackage : t1sc_pkg

// >>> common/t1sc_regs.svh
// Register word indices, field positions and reset values of the signaling change bank
`ifndef T1SC_REGS_SVH
`define T1SC_REGS_SVH
`define T1SC_IDX_SIG_0_7      12'h10d
`define T1SC_IDX_SIG_8_15     12'h10e
`define T1SC_IDX_SIG_16_23    12'h10f
`define T1SC_IDX_FRAME_CTRL   12'h112
`define T1SC_IDX_INT_STATUS   12'h114
`define T1SC_IDX_INT_MASK     12'h115
`define T1SC_BIT_IN_FRAME     7
`define T1SC_BIT_AIS          5
`define T1SC_BIT_ALARM_MASK   4
`define T1SC_BIT_YEL_EN       3
`define T1SC_BIT_YEL_DIR      2
`define T1SC_BIT_YEL_DATA     6
`define T1SC_CTRL_WMASK       8'h3c
`define T1SC_RST_BYTE         8'h00
`define T1SC_RST_SIG          24'h000000
`define T1SC_RST_INT          4'h0
`define T1SC_INT_SIG          0
`define T1SC_INT_LOF          1
`define T1SC_INT_FRAME_ALIGNMENT_CHANGE_ALARM         2
`define T1SC_INT_FE           3
`define T1SC_SLOTS            24
`endif

// >>> dv/t1sc_bank_bench.sv
// Register, interrupt and data path tests of the signaling change bank
`timescale 1ns/10ps
module t1sc_bank_bench;
  logic clock_i = 0, reset_n_i = 0, clk_en_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
  logic [13:0] paddr_i = 0;
  logic [31:0] pwdata_i = 0, prdata_o, rv;
  logic pready_o, pslverr_o, cas_mode_i = 1, in_frame_i = 0, frame_align_change_i = 0;
  logic framing_error_i = 0, rx_ser_i = 0, rx_ds0_bit_i = 0, tx_line_i = 0, tx_ds0_bit_i = 0;
  logic [23:0] sig_change_i = 0;
  logic receive_serial_output_o, egress_line_transmit_o, framing_alarm_mask_o, irq_o, ev;
  logic [13:0] adr [6] = '{14'h434, 14'h438, 14'h43c, 14'h448, 14'h450, 14'h454};
  int miscompares = 0, n_compared = 0;
  t1sc_bank i_t1sc_bank (.*);
  initial forever #10 clock_i = ~clock_i;
  task automatic give_verdict;
    if (miscompares == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  task automatic chk(input string s, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s exp %h seen %h", s, exp, seen);
    end
  endtask : chk
  // Request held until pready is sampled high; the bound cuts a hang short
  task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock_i);
    psel_i <= 1'h1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clock_i);
    penable_i <= 1'h1;
    do begin
      @(posedge clock_i);
      n++;
      if (n > 9) begin
        miscompares++;
        give_verdict();
      end
    end while (pready_o !== 1'h1);
    rv = prdata_o;
    ev = pslverr_o;
    psel_i <= 1'h0;
    penable_i <= 1'h0;
  endtask : apb
  task automatic rdc(input logic [13:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk("prdata", rv, e);
  endtask : rdc
  task automatic pls(input logic [23:0] v, input logic f);
    @(posedge clock_i);
    sig_change_i <= v;
    framing_error_i <= f;
    @(posedge clock_i);
    sig_change_i <= 24'h0;
    framing_error_i <= 1'h0;
  endtask : pls
  task automatic dp(input logic [7:0] c, input logic d, r, t, er, et);
    apb(1'h1, 14'h448, {24'h0, c});
    rx_ds0_bit_i <= d;
    tx_ds0_bit_i <= d;
    rx_ser_i <= r;
    tx_line_i <= t;
    repeat (2) @(posedge clock_i);
    chk("rx_out", receive_serial_output_o, er);
    chk("tx_out", egress_line_transmit_o, et);
  endtask : dp
  initial begin
    repeat (4) @(posedge clock_i);
    reset_n_i <= 1'h1;
    foreach (adr[i]) rdc(adr[i], 32'h0);
    pls(24'h808001, 1'h0);
    rdc(14'h434, 32'h80);
    rdc(14'h438, 32'h80);
    rdc(14'h43c, 32'h01);
    rdc(14'h434, 32'h0);
    cas_mode_i <= 1'h0;
    pls(24'h000100, 1'h0);
    rdc(14'h438, 32'h0);
    chk("irq", irq_o, 1'h0);
    apb(1'h1, 14'h454, 32'h1);
    repeat (2) @(posedge clock_i);
    chk("irq", irq_o, 1'h1);
    apb(1'h1, 14'h450, 32'h1);
    repeat (2) @(posedge clock_i);
    chk("irq", irq_o, 1'h0);
    apb(1'h0, 14'h435, 32'h0);
    chk("pslverr", ev, 1'h1);
    in_frame_i <= 1'h1;
    apb(1'h1, 14'h448, 32'hff);
    rdc(14'h448, 32'hbc);
    in_frame_i <= 1'h0;
    pls(24'h0, 1'h1);
    rdc(14'h450, 32'h0);
    rdc(14'h448, 32'h3c);
    dp(8'h20, 1'h1, 1'h0, 1'h1, 1'h1, 1'h1);
    dp(8'h00, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1);
    dp(8'h0c, 1'h1, 1'h1, 1'h1, 1'h0, 1'h1);
    dp(8'h08, 1'h1, 1'h1, 1'h1, 1'h1, 1'h0);
    dp(8'h08, 1'h0, 1'h1, 1'h1, 1'h1, 1'h1);
    pls(24'h0, 1'h1);
    rdc(14'h450, 32'h8);
    cas_mode_i <= 1'h1;
    pls(24'h800000, 1'h0);
    fork
      rdc(14'h434, 32'h80);
      begin
        repeat (2) @(posedge clock_i);
        sig_change_i <= 24'h400000;
        @(posedge clock_i);
        sig_change_i <= 24'h0;
      end
    join
    rdc(14'h434, 32'h40);
    clk_en_i <= 1'h0;
    pls(24'h008000, 1'h0);
    clk_en_i <= 1'h1;
    rdc(14'h438, 32'h0);
    in_frame_i <= 1'h1;
    repeat (2) @(posedge clock_i);
    in_frame_i <= 1'h0;
    frame_align_change_i <= 1'h1;
    @(posedge clock_i);
    frame_align_change_i <= 1'h0;
    rdc(14'h450, 32'hf);
    give_verdict();
  end
endmodule : t1sc_bank_bench

// >>> dv/t1sc_bank_monitor.sv
// Checker of bus timing, the egress pass-through path and the alarm mask output
`timescale 1ns/10ps
module t1sc_bank_monitor (
  input wire logic        clock_i, reset_n_i, clk_en_i, psel_i, penable_i, pwrite_i,
  input wire logic [13:0] paddr_i,
  input wire logic [31:0] pwdata_i, prdata_o,
  input wire logic        pready_o, pslverr_o, tx_line_i, tx_ds0_bit_i,
  input wire logic        egress_line_transmit_o, framing_alarm_mask_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  sequence acc_s;
    psel_i && penable_i && clk_en_i && !pready_o;
  endsequence
  wire ctrl_w = pready_o && paddr_i == 14'h448;
  pready_pulse_a: assert property (pready_o |=> !pready_o) else $error("pready held");
  wait_state_a: assert property (acc_s |=> pready_o) else $error("no answer");
  upper_zero_a: assert property (pready_o |-> prdata_o[31:8] == 24'h0) else $error("upper");
  misalign_err_a: assert property (pready_o && paddr_i[1:0] != 2'h0 |-> pslverr_o)
    else $error("no error");
  reserved_zero_a: assert property (ctrl_w && !pwrite_i |-> (prdata_o & 32'h43) == 32'h0)
    else $error("reserved bits");
  egress_pass_a: assert property (!tx_ds0_bit_i && clk_en_i |=>
    egress_line_transmit_o == $past(tx_line_i)) else $error("egress path");
  mask_follow_a: assert property (ctrl_w && pwrite_i |=>
    framing_alarm_mask_o == $past(pwdata_i[4])) else $error("mask copy");
  reset_unmask_a: assert property ($rose(reset_n_i) |-> !framing_alarm_mask_o)
    else $error("mask after reset");
endmodule : t1sc_bank_monitor
bind t1sc_bank t1sc_bank_monitor i_t1sc_bank_monitor (.*);

// >>> src/t1sc_bank.sv
// T1 receive signaling change flags, frame state and alarm controls behind APB
`timescale 1ns/10ps
`include "t1sc_regs.svh"
module t1sc_bank (
  // Clock, reset, enable
  input  wire logic        clock_i,
  input  wire logic        reset_n_i,
  input  wire logic        clk_en_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [13:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Receive and transmit framer side
  input  wire logic        cas_mode_i,
  input  wire logic [23:0] sig_change_i,
  input  wire logic        in_frame_i,
  input  wire logic        frame_align_change_i,
  input  wire logic        framing_error_i,
  input  wire logic        rx_ser_i,
  input  wire logic        rx_ds0_bit_i,
  input  wire logic        tx_line_i,
  input  wire logic        tx_ds0_bit_i,
  // Data outputs
  output logic             receive_serial_output_o,
  output logic             egress_line_transmit_o,
  output logic             framing_alarm_mask_o,
  // Interrupt
  output logic             irq_o
);
  t1sc_pkg::t1sc_slots_type sig_q;
  t1sc_pkg::t1sc_byte_type  ctrl_q;
  t1sc_pkg::t1sc_byte_type  ctrl_d;
  t1sc_pkg::t1sc_int_type   ist_q;
  t1sc_pkg::t1sc_int_type   ist_d;
  t1sc_pkg::t1sc_int_type   ist_clr_w;
  t1sc_pkg::t1sc_int_type   imask_q;
  t1sc_pkg::t1sc_int_type   imask_d;
  t1sc_pkg::t1sc_byte_type  rbyte;
  logic                     in_frame_q;
  logic                     access_w;
  logic                     rd_w;
  logic                     wr_w;
  logic                     aligned_w;
  logic [11:0]              idx_w;
  logic                     hit_s0;
  logic                     hit_s1;
  logic                     hit_s2;
  logic                     hit_fc;
  logic                     hit_is;
  logic                     hit_im;
  logic                     mapped_w;
  logic                     clr_s0_w;
  logic                     clr_s1_w;
  logic                     clr_s2_w;
  t1sc_pkg::t1sc_slots_type set_w;
  t1sc_pkg::t1sc_int_type   ev_w;
  logic                     alarm_mask_w;
  logic                     ais_w;
  logic                     yel_w;
  logic                     yel_dir_w;
  logic                     rx_yel_w;
  logic                     tx_yel_w;
  logic                     rx_out_d;
  logic                     tx_out_d;
  logic                     irq_d;
  logic [31:0]              prdata_d;

  // Decode; registers are 32-bit words at four times their index
  assign access_w  = psel_i & penable_i & ~pready_o & clk_en_i;
  assign rd_w      = access_w & ~pwrite_i;
  assign wr_w      = access_w & pwrite_i;
  assign aligned_w = (paddr_i[1:0] == 2'h0);
  assign idx_w     = paddr_i[13:2];
  assign hit_s0    = aligned_w & (idx_w == `T1SC_IDX_SIG_0_7);
  assign hit_s1    = aligned_w & (idx_w == `T1SC_IDX_SIG_8_15);
  assign hit_s2    = aligned_w & (idx_w == `T1SC_IDX_SIG_16_23);
  assign hit_fc    = aligned_w & (idx_w == `T1SC_IDX_FRAME_CTRL);
  assign hit_is    = aligned_w & (idx_w == `T1SC_IDX_INT_STATUS);
  assign hit_im    = aligned_w & (idx_w == `T1SC_IDX_INT_MASK);
  assign mapped_w  = hit_s0 | hit_s1 | hit_s2 | hit_fc | hit_is | hit_im;

  // Flag layout: sig_q[23] is slot 0, sig_q[0] is slot 23
  // Each byte clears only on a read of its own register
  assign clr_s0_w = rd_w & hit_s0;
  assign clr_s1_w = rd_w & hit_s1;
  assign clr_s2_w = rd_w & hit_s2;
  assign set_w    = cas_mode_i ? sig_change_i : `T1SC_RST_SIG;

  // Slots 0 to 7
  t1sc_flag_byte #(
    .WIDTH (8)
  ) i_flags_s0 (
    .clock_i   (clock_i),
    .reset_n_i (reset_n_i),
    .clk_en_i  (clk_en_i),
    .clear_i   (clr_s0_w),
    .set_i     (set_w[23:16]),
    .flags_o   (sig_q[23:16])
  );

  // Slots 8 to 15
  t1sc_flag_byte #(
    .WIDTH (8)
  ) i_flags_s1 (
    .clock_i   (clock_i),
    .reset_n_i (reset_n_i),
    .clk_en_i  (clk_en_i),
    .clear_i   (clr_s1_w),
    .set_i     (set_w[15:8]),
    .flags_o   (sig_q[15:8])
  );

  // Slots 16 to 23
  t1sc_flag_byte #(
    .WIDTH (8)
  ) i_flags_s2 (
    .clock_i   (clock_i),
    .reset_n_i (reset_n_i),
    .clk_en_i  (clk_en_i),
    .clear_i   (clr_s2_w),
    .set_i     (set_w[7:0]),
    .flags_o   (sig_q[7:0])
  );

  // Reserved and read-only bits are dropped on write
  assign ctrl_d = (wr_w & hit_fc) ? (pwdata_i[7:0] & `T1SC_CTRL_WMASK) : ctrl_q;

  // Events raise sticky status; write one to clear, but a new event wins
  assign alarm_mask_w = ctrl_q[`T1SC_BIT_ALARM_MASK];
  assign ev_w[`T1SC_INT_SIG]  = |set_w;
  assign ev_w[`T1SC_INT_LOF]  = in_frame_q & ~in_frame_i & ~alarm_mask_w;
  assign ev_w[`T1SC_INT_FRAME_ALIGNMENT_CHANGE_ALARM] = frame_align_change_i & ~alarm_mask_w;
  assign ev_w[`T1SC_INT_FE]   = framing_error_i & ~alarm_mask_w;
  assign ist_clr_w = (wr_w & hit_is) ? pwdata_i[3:0] : `T1SC_RST_INT;
  assign ist_d     = (ist_q & ~ist_clr_w) | ev_w;
  assign imask_d   = (wr_w & hit_im) ? pwdata_i[3:0] : imask_q;
  // Taken from the next status so a fresh event is not held back a cycle
  assign irq_d     = |(ist_d & imask_q);

  // Read mux; in-frame is live state, reserved bits read zero
  assign rbyte = hit_s0 ? sig_q[23:16] :
                 hit_s1 ? sig_q[15:8] :
                 hit_s2 ? sig_q[7:0] :
                 hit_fc ? (ctrl_q | {in_frame_q, 7'h00}) :
                 hit_is ? {4'h0, ist_q} :
                 hit_im ? {4'h0, imask_q} : `T1SC_RST_BYTE;
  assign prdata_d = rd_w ? {24'h000000, rbyte} : prdata_o;

  // Datapath controls
  assign ais_w     = ctrl_q[`T1SC_BIT_AIS];
  assign yel_w     = ctrl_q[`T1SC_BIT_YEL_EN];
  assign yel_dir_w = ctrl_q[`T1SC_BIT_YEL_DIR];
  assign rx_yel_w  = yel_w & yel_dir_w & rx_ds0_bit_i;
  assign tx_yel_w  = yel_w & ~yel_dir_w & tx_ds0_bit_i;

  // AIS wins over ingress yellow: the whole stream is replaced, framing too
  assign rx_out_d = ais_w ? 1'b1 : (rx_yel_w ? 1'b0 : rx_ser_i);
  // Only bit 2 of a DS-0 is forced; the framer supplies the strobe
  assign tx_out_d = tx_yel_w ? 1'b0 : tx_line_i;

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      ctrl_q <= `T1SC_RST_BYTE;
    end else if (clk_en_i) begin
      ctrl_q <= ctrl_d;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      ist_q <= `T1SC_RST_INT;
    end else if (clk_en_i) begin
      ist_q <= ist_d;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      imask_q <= `T1SC_RST_INT;
    end else if (clk_en_i) begin
      imask_q <= imask_d;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      in_frame_q <= 1'b0;
    end else if (clk_en_i) begin
      in_frame_q <= in_frame_i;
    end
  end

  // Bus answer: one wait state, error on unmapped or misaligned address
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      pready_o <= 1'b0;
    end else if (clk_en_i) begin
      pready_o <= access_w;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      pslverr_o <= 1'b0;
    end else if (clk_en_i) begin
      pslverr_o <= access_w & ~mapped_w;
    end
  end

  // Read data holds until the next read so a slow master still sees it
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      prdata_o <= 32'h00000000;
    end else if (clk_en_i) begin
      prdata_o <= prdata_d;
    end
  end

  // Interrupt and data outputs all come from flip-flops
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      irq_o <= 1'b0;
    end else if (clk_en_i) begin
      irq_o <= irq_d;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      framing_alarm_mask_o <= 1'b0;
    end else if (clk_en_i) begin
      framing_alarm_mask_o <= alarm_mask_w;
    end
  end

  // Idles high so the receive side looks like an alarm until data flows
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      receive_serial_output_o <= 1'b1;
    end else if (clk_en_i) begin
      receive_serial_output_o <= rx_out_d;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      egress_line_transmit_o <= 1'b0;
    end else if (clk_en_i) begin
      egress_line_transmit_o <= tx_out_d;
    end
  end
endmodule : t1sc_bank

// One read-clear byte of change flags
module t1sc_flag_byte #(
  parameter int unsigned WIDTH = 8
) (
  // Clock, reset, enable
  input  wire logic             clock_i,
  input  wire logic             reset_n_i,
  input  wire logic             clk_en_i,
  // Flag control
  input  wire logic             clear_i,
  input  wire logic [WIDTH-1:0] set_i,
  // Flag state
  output logic      [WIDTH-1:0] flags_o
);
  logic [WIDTH-1:0] flags_d;

  // Clear first, then set, so a change in the read cycle is not lost
  assign flags_d = (flags_o & ~{WIDTH{clear_i}}) | set_i;

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      flags_o <= '0;
    end else if (clk_en_i) begin
      flags_o <= flags_d;
    end
  end
endmodule : t1sc_flag_byte
